// ===== design/qrl_consts.svh
`ifndef QRL_CONSTS_SVH
`define QRL_CONSTS_SVH
// Functional notes
// R01: feature pair gives 16-bit read length
// R02: host tags unique among outstanding queued reads
// R03: host tag within reported queue depth
// R04: rebuild flag honoured only when supported, enabled
// R05: priority class in previous count bits 7:6
// R06: high priority first, isochronous before deadline
// R07: 48-bit address spread over three register pairs
// R08: deadline code used only for isochronous class
// R09: expired deadline keeps running unless abort chosen
// R10: fine deadline is (code+1) times 10 ms
// R11: coarse deadline is (code+1) times 0.5 s
// R12: force flag reads media, bypassing buffer
// R13: without force flag cache may serve data
// R14: failing address readable, byte half selectable
// R15: log read interrupts per data block
// R16: log count, address, start offset fields
// R17: log transfer begins at requested start offset
// R18: supported read-only logs and host logs
// R19: log address 06h always aborts
// R20: serial logs 10h-12h, 15h; reserved abort
// R21: extended self-test log holds both entry kinds
// R22: unsupported log or invalid fields abort
// R23: uncorrectable error stops read at failing sector
// R24: host logs are sixteen sectors long
// R25: abort sets abort, error bits, clears busy
// R26: accept only opcodes 60h and 2Fh

// ==================================================
// register byte offsets
`define OFS_FEATURE   8'h00
`define OFS_SECCNT    8'h04
`define OFS_SECNUM    8'h08
`define OFS_CYLLO     8'h0C
`define OFS_CYLHI     8'h10
`define OFS_DEVHEAD   8'h14
`define OFS_CMDSTAT   8'h18
`define OFS_ERROR     8'h1C
`define OFS_CTRL      8'h20
`define OFS_QINFO     8'h24
// ==================================================
// opcodes and status / error bits
`define OPC_QREAD     8'h60
`define OPC_LOGREAD   8'h2F
`define ST_BSY        7
`define ST_RDY        6
`define ST_ERR        0
`define ER_UNC        6
`define ER_ABT        2
`define FORCE_BIT     7
// ==================================================
// control register fields and reset
`define CTL_HOB       0
`define CTL_RB_SUP    1
`define CTL_RB_EN     2
`define CTL_DL_ABORT  3
`define CTL_NCQ       4
`define CTL_PHY       5
`define CTL_QMGT      6
`define CTL_SMART     7
`define CTL_EPC       8
`define CTL_STREAM    9
`define CTL_RESET     10'h3F0
// ==================================================
// priority classes and log addresses
`define PRIORITY_CLASS_NORMAL   2'b00
`define PRIORITY_CLASS_ISO      2'b01
`define PRIORITY_CLASS_HIGH     2'b10
`define LOG_DIR       8'h00
`define LOG_SMART_ERR 8'h03
`define LOG_SELFTEST  8'h06
`define LOG_EXT_TEST  8'h07
`define LOG_POWER     8'h08
`define LOG_QERR      8'h10
`define LOG_PHY       8'h11
`define LOG_QMGT      8'h12
`define LOG_REBUILD   8'h15
`define LOG_WSTREAM   8'h21
`define LOG_RSTREAM   8'h22
`define LOG_IDENT     8'h30
`define LOG_HOST_LO   8'h80
`define LOG_HOST_HI   8'h9F
`define HOST_LOG_SECTORS 17'h00010
// ==================================================
// timing
`define CLK_HZ        10000000
`define FINE_MS       10
`define COARSE_MS     500
`define FINE_CYCLES   (`FINE_MS * (`CLK_HZ / 1000))
`define COARSE_CYCLES (`COARSE_MS * (`CLK_HZ / 1000))
`endif

// ===== design/qrl_pkg.sv
package qrl_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_QREAD, ST_LOG} cmd_state_e;
  typedef logic [7:0] byte_t;
endpackage

// ===== design/byte_pair.sv
// ==================================================
// current / previous shadow pair: each write pushes the old byte back
module byte_pair
  import qrl_pkg::*;
(
  input  wire logic  clk_sys,
  input  wire logic  rst_n,
  input  wire logic  load,
  input  wire byte_t din,
  output byte_t      cur,
  output byte_t      prev
);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur  <= 8'h00;
      prev <= 8'h00;
    end
    else if (load)
    begin
      prev <= cur;
      cur  <= din;
    end
  end
endmodule

// ===== design/qrl_decoder.sv
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`include "qrl_consts.svh"
module qrl_decoder
  import qrl_pkg::*;
#(
  parameter logic [31:0] FINE_CYCLES   = 32'(`FINE_CYCLES),
  parameter logic [31:0] COARSE_CYCLES = 32'(`COARSE_CYCLES)
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             media_start,
  output logic             media_stop,
  output logic [47:0]      media_lba,
  output logic [15:0]      media_count,
  output logic [4:0]       media_tag,
  output logic [1:0]       media_priority,
  output logic             media_bypass_cache,
  output logic             media_rebuild,
  input  wire logic        media_done,
  input  wire logic        media_unc,
  input  wire logic [47:0] media_fail_lba,
  output logic             log_start,
  output logic [7:0]       log_sel,
  output logic [15:0]      log_offset,
  output logic [15:0]      log_count,
  input  wire logic        log_block_done,
  input  wire logic        log_done,
  output logic             host_intrq,
  output logic             deadline_expired
);
  // ==================================================
  // bus slave: address phase capture
  logic        wr_pend;
  logic [7:0]  wr_addr;
  cmd_state_e  state;
  cmd_state_e  next_state;
  logic [9:0]  ctrl;
  logic [7:0]  status;
  logic [7:0]  error;
  logic [47:0] fail_lba;
  logic [7:0]  dl_code;
  logic        dl_active;
  logic [31:0] dl_count;
  logic [31:0] dl_limit;

  wire        addr_phase = hsel && hready && htrans[1];
  wire        rd_req     = addr_phase && !hwrite;
  wire [7:0]  rd_addr    = haddr[7:0];
  wire [7:0]  wbyte      = hwdata[7:0];
  wire        busy       = (state != ST_IDLE);

  wire ld_feature = wr_pend && (wr_addr == `OFS_FEATURE);
  wire ld_seccnt  = wr_pend && (wr_addr == `OFS_SECCNT);
  wire ld_secnum  = wr_pend && (wr_addr == `OFS_SECNUM);
  wire ld_cyllo   = wr_pend && (wr_addr == `OFS_CYLLO);
  wire ld_cylhi   = wr_pend && (wr_addr == `OFS_CYLHI);
  wire ld_devhead = wr_pend && (wr_addr == `OFS_DEVHEAD);
  wire ld_ctrl    = wr_pend && (wr_addr == `OFS_CTRL);
  // commands written while busy are dropped
  wire ld_cmd     = wr_pend && (wr_addr == `OFS_CMDSTAT) && !busy;

  // ==================================================
  // taskfile pairs
  byte_t feat_c, feat_p, cnt_c, cnt_p, snum_c, snum_p, clo_c, clo_p, chi_c, chi_p;
  byte_t devhead;

  byte_pair u_feature (.clk_sys(clk_sys), .rst_n(rst_n), .load(ld_feature), .din(wbyte),
                       .cur(feat_c), .prev(feat_p));
  byte_pair u_seccnt  (.clk_sys(clk_sys), .rst_n(rst_n), .load(ld_seccnt), .din(wbyte),
                       .cur(cnt_c), .prev(cnt_p));
  byte_pair u_secnum  (.clk_sys(clk_sys), .rst_n(rst_n), .load(ld_secnum), .din(wbyte),
                       .cur(snum_c), .prev(snum_p));
  byte_pair u_cyllo   (.clk_sys(clk_sys), .rst_n(rst_n), .load(ld_cyllo), .din(wbyte),
                       .cur(clo_c), .prev(clo_p));
  byte_pair u_cylhi   (.clk_sys(clk_sys), .rst_n(rst_n), .load(ld_cylhi), .din(wbyte),
                       .cur(chi_c), .prev(chi_p));

  // ==================================================
  // command field decode
  wire        is_qread   = ld_cmd && (wbyte == `OPC_QREAD);   // [R26]
  wire        is_logread = ld_cmd && (wbyte == `OPC_LOGREAD); // [R26]
  wire [15:0] q_length   = {feat_p, feat_c};                  // [R01]
  wire [4:0]  q_tag      = cnt_c[7:3];
  wire [1:0]  q_priority_class     = cnt_p[7:6];                        // [R05]
  wire        rb_on      = ctrl[`CTL_RB_SUP] && ctrl[`CTL_RB_EN];
  wire        q_rebuild  = cnt_c[0] && rb_on;                 // [R04]
  wire [47:0] q_lba      = {chi_p, clo_p, snum_p, chi_c, clo_c, snum_c}; // [R07]
  wire        q_iso      = (q_priority_class == `PRIORITY_CLASS_ISO);             // [R08]
  wire        q_force    = devhead[`FORCE_BIT];               // [R12] [R13]
  wire [31:0] dl_unit    = feat_c[7] ? COARSE_CYCLES : FINE_CYCLES; // [R10] [R11]
  wire [31:0] dl_steps   = {25'h0000000, feat_c[6:0]} + 32'h00000001;
  wire [31:0] q_dl_limit = 32'(dl_steps * dl_unit);          // [R10] [R11]

  // log read fields and validation
  wire [15:0] l_count    = {cnt_p, cnt_c};                    // [R16]
  wire [7:0]  l_addr     = snum_c;                            // [R16]
  wire [15:0] l_offset   = {clo_p, clo_c};                    // [R16] [R17]
  wire        l_host     = (l_addr >= `LOG_HOST_LO) && (l_addr <= `LOG_HOST_HI);
  wire [16:0] l_end      = {1'b0, l_offset} + {1'b0, l_count};
  wire        l_host_ok  = l_host && (l_end <= `HOST_LOG_SECTORS);   // [R24]
  wire        l_sup =
    (l_addr == `LOG_DIR) || (l_addr == `LOG_IDENT) ||                 // [R18]
    ((l_addr == `LOG_SMART_ERR) && ctrl[`CTL_SMART]) ||
    ((l_addr == `LOG_EXT_TEST) && ctrl[`CTL_SMART]) ||                // [R21]
    ((l_addr == `LOG_POWER) && ctrl[`CTL_EPC]) ||
    ((l_addr == `LOG_QERR) && ctrl[`CTL_NCQ]) ||                      // [R20]
    ((l_addr == `LOG_PHY) && ctrl[`CTL_PHY]) ||                       // [R20]
    ((l_addr == `LOG_QMGT) && ctrl[`CTL_QMGT]) ||                     // [R20]
    ((l_addr == `LOG_REBUILD) && ctrl[`CTL_RB_SUP]) ||                // [R20]
    (((l_addr == `LOG_WSTREAM) || (l_addr == `LOG_RSTREAM)) && ctrl[`CTL_STREAM]) ||
    (l_host_ok && ctrl[`CTL_SMART]);                                  // [R18]
  // address 06h and reserved ones fall outside l_sup and abort
  wire        l_ok       = l_sup && (l_count != 16'h0000) &&
                           (l_addr != `LOG_SELFTEST);                 // [R19] [R22]
  wire        log_abort  = is_logread && !l_ok;                       // [R22]

  // ==================================================
  // deadline tracking
  wire dl_hit   = dl_active && (dl_count >= dl_limit);
  wire dl_abort = dl_hit && ctrl[`CTL_DL_ABORT];        // [R09]
  wire q_finish = (state == ST_QREAD) && (media_done || media_unc || dl_abort);
  wire l_finish = (state == ST_LOG) && log_done;

  // ==================================================
  // command state
  always_comb
  begin
    next_state = state;
    case (state)
      ST_IDLE:
      begin
        if (is_qread)
          next_state = ST_QREAD;
        else if (is_logread && l_ok)
          next_state = ST_LOG;
      end
      ST_QREAD:
      begin
        if (q_finish)
          next_state = ST_IDLE;
      end
      ST_LOG:
      begin
        if (l_finish)
          next_state = ST_IDLE;
      end
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  // ==================================================
  // bus write capture and control register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      devhead <= 8'h00;
      ctrl    <= `CTL_RESET;
    end
    else
    begin
      wr_pend <= addr_phase && hwrite;
      wr_addr <= haddr[7:0];
      if (ld_devhead)
        devhead <= wbyte;
      if (ld_ctrl)
        ctrl <= hwdata[9:0];
    end
  end

  // ==================================================
  // status, error and failing address
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status   <= 8'h40;
      error    <= 8'h00;
      fail_lba <= 48'h000000000000;
    end
    else if (ld_cmd)
    begin
      status <= 8'h40;
      error  <= 8'h00;
      if (log_abort)
      begin
        status[`ST_ERR] <= 1'b1;                        // [R25]
        error[`ER_ABT]  <= 1'b1;                        // [R25] [R19] [R22]
      end
      else if (is_qread || is_logread)
        status[`ST_BSY] <= 1'b1;
    end
    else if (q_finish || l_finish)
    begin
      status[`ST_BSY] <= 1'b0;                          // [R25]
      if ((state == ST_QREAD) && media_unc)
      begin
        status[`ST_ERR] <= 1'b1;
        error[`ER_UNC]  <= 1'b1;
        fail_lba        <= media_fail_lba;              // [R14] [R23]
      end
      else if ((state == ST_QREAD) && dl_abort)
      begin
        status[`ST_ERR] <= 1'b1;                        // [R25]
        error[`ER_ABT]  <= 1'b1;                        // [R09]
      end
    end
  end

  // ==================================================
  // media side outputs
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      media_start        <= 1'b0;
      media_stop         <= 1'b0;
      media_lba          <= 48'h000000000000;
      media_count        <= 16'h0000;
      media_tag          <= 5'h00;
      media_priority     <= `PRIORITY_CLASS_NORMAL;
      media_bypass_cache <= 1'b0;
      media_rebuild      <= 1'b0;
    end
    else
    begin
      media_start <= is_qread;
      // halts the media at the failing sector or on deadline abort
      media_stop  <= (state == ST_QREAD) && (media_unc || dl_abort); // [R23]
      if (is_qread)
      begin
        media_lba          <= q_lba;                    // [R07]
        media_count        <= q_length;                 // [R01]
        media_tag          <= q_tag;                    // [R02]
        media_priority     <= q_priority_class;                   // [R05] [R06]
        media_bypass_cache <= q_force;                  // [R12] [R13]
        media_rebuild      <= q_rebuild;                // [R04]
      end
      else if (dl_hit && (media_priority == `PRIORITY_CLASS_ISO))
        media_priority <= `PRIORITY_CLASS_HIGH;                   // [R06] [R09]
    end
  end

  // ==================================================
  // deadline timer
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dl_active        <= 1'b0;
      dl_count         <= 32'h00000000;
      dl_limit         <= 32'h00000000;
      dl_code          <= 8'h00;
      deadline_expired <= 1'b0;
    end
    else if (is_qread)
    begin
      dl_active        <= q_iso;                        // [R08]
      dl_count         <= 32'h00000000;
      dl_limit         <= q_dl_limit;                   // [R10] [R11]
      dl_code          <= feat_c;
      deadline_expired <= 1'b0;
    end
    else
    begin
      if (q_finish)
        dl_active <= 1'b0;
      if (dl_hit)
        deadline_expired <= 1'b1;                       // [R09]
      else if (dl_active)
        dl_count <= dl_count + 32'h00000001;
    end
  end

  // ==================================================
  // log side outputs and host interrupt
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      log_start  <= 1'b0;
      log_sel    <= 8'h00;
      log_offset <= 16'h0000;
      log_count  <= 16'h0000;
      host_intrq <= 1'b0;
    end
    else
    begin
      log_start <= is_logread && l_ok;
      if (is_logread)
      begin
        log_sel    <= l_addr;                           // [R16]
        log_offset <= l_offset;                         // [R17]
        log_count  <= l_count;                          // [R16]
      end
      host_intrq <= ((state == ST_LOG) && log_block_done) ||  // [R15]
                    q_finish || log_abort;              // [R25]
    end
  end

  // ==================================================
  // read mux
  wire [7:0] lba_sn = ctrl[`CTL_HOB] ? fail_lba[31:24] : fail_lba[7:0];   // [R14]
  wire [7:0] lba_cl = ctrl[`CTL_HOB] ? fail_lba[39:32] : fail_lba[15:8];  // [R14]
  wire [7:0] lba_ch = ctrl[`CTL_HOB] ? fail_lba[47:40] : fail_lba[23:16]; // [R14]
  wire [31:0] qinfo = {dl_code, 3'b000, deadline_expired, media_rebuild,
                       media_bypass_cache, media_priority, 3'b000, media_tag, media_count[7:0]};
  logic [31:0] rd_mux;
  always_comb
  begin
    if (rd_addr == `OFS_SECNUM)
      rd_mux = {24'h000000, lba_sn};
    else if (rd_addr == `OFS_CYLLO)
      rd_mux = {24'h000000, lba_cl};
    else if (rd_addr == `OFS_CYLHI)
      rd_mux = {24'h000000, lba_ch};
    else if (rd_addr == `OFS_DEVHEAD)
      rd_mux = {24'h000000, devhead};
    else if (rd_addr == `OFS_CMDSTAT)
      rd_mux = {24'h000000, status};
    else if (rd_addr == `OFS_ERROR)
      rd_mux = {24'h000000, error};
    else if (rd_addr == `OFS_CTRL)
      rd_mux = {22'h000000, ctrl};
    else if (rd_addr == `OFS_QINFO)
      rd_mux = qinfo;
    else
      rd_mux = 32'h00000000;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      if (rd_req)
        hrdata <= rd_mux;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule

// ===== verif/qrl_chk.sv
module qrl_chk
(
  input wire logic        clk_sys,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hwdata,
  input wire logic        media_start,
  input wire logic        media_stop,
  input wire logic [47:0] media_lba,
  input wire logic [15:0] media_count,
  input wire logic [4:0]  media_tag,
  input wire logic [1:0]  media_priority,
  input wire logic        media_bypass_cache,
  input wire logic        media_unc,
  input wire logic        log_start,
  input wire logic        log_block_done,
  input wire logic        host_intrq,
  input wire logic        deadline_expired
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ==================================================
  // command register write: address phase then data phase
  sequence s_cmd_wr(logic [7:0] op);
    hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h18 ##1 hwdata[7:0] == op;
  endsequence
  sequence s_one_pulse;
    !media_start ##1 media_start ##1 !media_start;
  endsequence
  property p_qread_start;
    s_cmd_wr(8'h60) |-> s_one_pulse;
  endproperty
  a_qread_start: assert property (p_qread_start)
    else $error("queued read not launched as a single pulse");
  property p_log_cause;
    $rose(log_start) |-> $past(hwdata[7:0], 1) == 8'h2F;
  endproperty
  a_log_cause: assert property (p_log_cause)
    else $error("log start without log read command");
  property p_log_pulse;
    log_start |=> !log_start;
  endproperty
  a_log_pulse: assert property (p_log_pulse)
    else $error("log start longer than one cycle");
  property p_log_intr;
    log_block_done |=> host_intrq;
  endproperty
  a_log_intr: assert property (p_log_intr)
    else $error("no interrupt after log block");
  property p_unc_stop;
    media_unc |=> media_stop && host_intrq;
  endproperty
  a_unc_stop: assert property (p_unc_stop)
    else $error("read not stopped at failing sector");
  property p_stop_cause;
    $rose(media_stop) |-> $past(media_unc) || deadline_expired;
  endproperty
  a_stop_cause: assert property (p_stop_cause)
    else $error("stop without error or deadline");
  property p_fields_hold;
    !media_start |-> $stable({media_lba, media_count, media_tag, media_bypass_cache});
  endproperty
  a_fields_hold: assert property (p_fields_hold)
    else $error("read fields changed outside launch");
  property p_deadline;
    $rose(deadline_expired) |-> media_priority == 2'b10 && $past(media_priority) == 2'b01;
  endproperty
  a_deadline: assert property (p_deadline)
    else $error("deadline on non isochronous read");
endmodule

bind qrl_decoder qrl_chk u_chk (.*);

// ===== verif/qrl_media_model.sv
module qrl_media_model
(
  input  wire logic        clk_sys,
  input  wire logic        media_start,
  input  wire logic        log_start,
  input  wire logic [15:0] log_count,
  input  wire logic        unc_mode,
  input  wire logic [7:0]  delay,
  input  wire logic [47:0] fail_lba,
  output logic             media_done,
  output logic             media_unc,
  output logic [47:0]      media_fail_lba,
  output logic             log_block_done,
  output logic             log_done
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==================================================
  // media and log engine: answers after delay cycles
  initial
  begin
    media_done = 1'b0;
    media_unc = 1'b0;
    media_fail_lba = '1;
    log_block_done = 1'b0;
    log_done = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      if (media_start === 1'b1)
      begin
        repeat (delay) @(posedge clk_sys);
        media_done <= !unc_mode;
        media_unc <= unc_mode;
        media_fail_lba <= fail_lba;
        @(posedge clk_sys);
        media_done <= 1'b0;
        media_unc <= 1'b0;
        // address no longer valid: show its inverse
        media_fail_lba <= ~fail_lba;
      end
      else if (log_start === 1'b1)
      begin
        repeat (log_count)
        begin
          repeat (delay) @(posedge clk_sys);
          log_block_done <= 1'b1;
          @(posedge clk_sys);
          log_block_done <= 1'b0;
        end
        log_done <= 1'b1;
        @(posedge clk_sys);
        log_done <= 1'b0;
      end
    end
  end
endmodule

// ===== verif/queued_read_and_log_read_decoder_test.sv
module queued_read_and_log_read_decoder_test;
  import qrl_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys, rst_n, hsel, hwrite, unc_mode;
  logic [31:0] haddr, hwdata, hrdata, d;
  logic [1:0] htrans, media_priority;
  logic [2:0] hsize;
  wire logic hready;
  logic hreadyout, hresp, media_start, media_stop, media_bypass_cache, media_rebuild, media_done, media_unc;
  logic [47:0] media_lba, media_fail_lba, fail_lba;
  logic [15:0] media_count, log_offset, log_count;
  logic [4:0] media_tag;
  logic [7:0] log_sel, delay;
  logic log_start, log_block_done, log_done, host_intrq, deadline_expired;
  int n_fail, check_count, cyc, n_intr, n_start, n_log, seed;
  assign hready = hreadyout;
  qrl_decoder #(.FINE_CYCLES(32'd20), .COARSE_CYCLES(32'd200)) u_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .media_start(media_start),
    .media_stop(media_stop), .media_lba(media_lba), .media_count(media_count), .media_tag(media_tag),
    .media_priority(media_priority), .media_bypass_cache(media_bypass_cache), .media_rebuild(media_rebuild),
    .media_done(media_done), .media_unc(media_unc), .media_fail_lba(media_fail_lba), .log_start(log_start),
    .log_sel(log_sel), .log_offset(log_offset), .log_count(log_count), .log_block_done(log_block_done),
    .log_done(log_done), .host_intrq(host_intrq), .deadline_expired(deadline_expired));
  qrl_media_model u_media (.clk_sys(clk_sys), .media_start(media_start), .log_start(log_start),
    .log_count(log_count), .unc_mode(unc_mode), .delay(delay), .fail_lba(fail_lba), .media_done(media_done),
    .media_unc(media_unc), .media_fail_lba(media_fail_lba), .log_block_done(log_block_done), .log_done(log_done));
  always #50 clk_sys = ~clk_sys;
  // ==================================================
  // event counters and hang limit
  always @(posedge clk_sys)
  begin
    cyc++;
    if (host_intrq === 1'b1) n_intr++;
    if (media_start === 1'b1) n_start++;
    if (log_start === 1'b1) n_log++;
    if (cyc == 30000)
    begin
      n_fail++;
      print_verdict;
    end
  end
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  // ==================================================
  // single word transfer, held until hready seen high
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd_d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr_en;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hready !== 1'b1);
    rd_d = hrdata;
    check(hresp, 1'b0);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] rd_d);
    bus(1'b0, a, 32'h0, rd_d);
  endtask
  task automatic finish_cmd(input int ni, input logic [7:0] st, input logic [7:0] er);
    int n;
    n = 0;
    rd(8'h1C, d);
    do
    begin
      rd(8'h18, d);
      n++;
    end while (d[7] !== 1'b0 && n < 500);
    check(d[7:0], st);
    rd(8'h1C, d);
    check(d[7:0], er);
    check(n_intr, ni);
  endtask
  // ==================================================
  // queued read: tag i, class i%3, force i[0], rebuild gated by control
  task automatic qread(input int i, input logic unc);
    logic [47:0] lba;
    logic [15:0] cnt;
    logic sup, en;
    sup = i > 1;
    en = i != 2;
    lba = {16'($urandom), $urandom};
    cnt = 16'($urandom) & {8'hFF, {8{i % 3 != 1}}};
    fail_lba <= {16'($urandom), $urandom};
    unc_mode <= unc;
    delay <= i % 3 == 1 ? 8'h28 : 8'(1 + $urandom % 16);
    wr(8'h20, {22'h0, 10'h3F0 | {6'h0, i == 1, en, sup, 1'b0}});
    wr(8'h00, {24'h0, cnt[15:8]});
    wr(8'h00, {24'h0, cnt[7:0]});
    wr(8'h04, {24'h0, 2'(i % 3), 6'h0});
    wr(8'h04, {24'h0, i[4:0], 3'b001});
    for (int k = 0; k < 3; k++)
    begin
      wr(8'(8 + 4 * k), {24'h0, lba[24 + 8 * k +: 8]});
      wr(8'(8 + 4 * k), {24'h0, lba[8 * k +: 8]});
    end
    wr(8'h14, {24'h0, i[0], 7'h40});
    n_intr = 0;
    n_start = 0;
    wr(8'h18, 32'h60);
    finish_cmd(1, unc || i == 1 ? 8'h41 : 8'h40, unc ? 8'h40 : i == 1 ? 8'h04 : 8'h00);
    check(n_start, 1);
    check(media_lba, lba);
    check(media_count, cnt);
    check(media_tag, i[4:0]);
    check(media_priority, i % 3 == 1 ? 2'b10 : 2'(i % 3));
    check(media_bypass_cache, i[0]);
    check(media_rebuild, sup & en);
    check(deadline_expired, i % 3 == 1);
    for (int h = 0; h < 2 && unc; h++)
    begin
      wr(8'h20, {22'h0, 10'h3F0 | 10'(h)});
      for (int k = 0; k < 3; k++)
      begin
        rd(8'(8 + 4 * k), d);
        check(d[7:0], fail_lba[24 * h + 8 * k +: 8]);
      end
    end
  endtask
  task automatic logrd(input logic [7:0] adr, input logic [15:0] cnt, input logic [15:0] ofs,
                       input logic [9:0] ctl, input logic ab);
    delay <= 8'(1 + $urandom % 8);
    wr(8'h20, {22'h0, ctl});
    wr(8'h04, {24'h0, cnt[15:8]});
    wr(8'h04, {24'h0, cnt[7:0]});
    wr(8'h08, {24'h0, adr});
    wr(8'h0C, {24'h0, ofs[15:8]});
    wr(8'h0C, {24'h0, ofs[7:0]});
    n_intr = 0;
    n_log = 0;
    wr(8'h18, 32'h2F);
    finish_cmd(ab ? 1 : int'(cnt), ab ? 8'h41 : 8'h40, ab ? 8'h04 : 8'h00);
    check(n_log, !ab);
    if (!ab)
    begin
      check(log_sel, adr);
      check(log_offset, ofs);
      check(log_count, cnt);
    end
  endtask
  initial
  begin
    seed = $urandom(70701);
    clk_sys = 0;
    rst_n = 0;
    hsel = 0;
    haddr = 0;
    htrans = 0;
    hwrite = 0;
    hsize = 3'b010;
    hwdata = 0;
    unc_mode = 0;
    delay = 8'h01;
    fail_lba = 0;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    rd(8'h18, d);
    check(d, 32'h40);
    rd(8'h20, d);
    check(d, 32'h3F0);
    rd(8'h3C, d);
    check(d, 32'h0);
    for (int i = 0; i < 5; i++)
      qread(i, i == 4);
    logrd(8'h00, 2, 0, 10'h3F0, 0);
    logrd(8'h03, 1, 0, 10'h3F0, 0);
    logrd(8'h07, 3, 1, 10'h3F0, 0);
    logrd(8'h08, 1, 0, 10'h3F0, 0);
    logrd(8'h10, 2, 1, 10'h3F0, 0);
    logrd(8'h11, 1, 0, 10'h3F0, 0);
    logrd(8'h12, 1, 0, 10'h3F0, 0);
    logrd(8'h15, 1, 0, 10'h3F2, 0);
    logrd(8'h21, 1, 0, 10'h3F0, 0);
    logrd(8'h22, 1, 0, 10'h3F0, 0);
    logrd(8'h30, 1, 0, 10'h3F0, 0);
    logrd(8'h80, 4, 12, 10'h3F0, 0);
    logrd(8'h9F, 4, 13, 10'h3F0, 1);
    logrd(8'h06, 1, 0, 10'h3F0, 1);
    logrd(8'h13, 1, 0, 10'h3F0, 1);
    logrd(8'h16, 1, 0, 10'h3F0, 1);
    logrd(8'h10, 1, 0, 10'h3E0, 1);
    logrd(8'h03, 0, 0, 10'h3F0, 1);
    print_verdict;
  end
endmodule
